// ### design/ptrp_cfg.svh
`ifndef PTRP_CFG_SVH
`define PTRP_CFG_SVH

// register byte offsets on the apb bus
`define PTRP_ADDR_CMD 8'h00
`define PTRP_ADDR_STATUS 8'h04
`define PTRP_ADDR_DATA 8'h08
`define PTRP_ADDR_MODE 8'h0C
`define PTRP_ADDR_W 8

// command byte fields, leftmost printed bit is the data msb
`define PTRP_CMD_DISABLE 7
`define PTRP_CMD_ENABLE 6
`define PTRP_CMD_STOP 5
`define PTRP_CMD_RUN 4
`define PTRP_CMD_STEP 3
`define PTRP_CMD_CONT 2
`define PTRP_CMD_WRITE 1
`define PTRP_CMD_READ 0

// status byte fields
`define PTRP_ST_OVERRUN 7
`define PTRP_ST_STOPPED 4
`define PTRP_ST_WAIT 3
`define PTRP_ST_ATTN 2
`define PTRP_ST_UNAVAIL 0

// mode register fields
`define PTRP_MODE_INTEN 0
`define PTRP_MODE_RUNNING 1
`define PTRP_MODE_STEP 2
`define PTRP_MODE_PUNCH 3
`define PTRP_MODE_PWR 4
`define PTRP_MODE_FULL 5

`define PTRP_CHAR_W 8
`define PTRP_DATA_W 32

`endif

// ### design/ptrp_pkg.sv
package ptrp_pkg;
	// reader tape motion states
	typedef enum logic [1:0] {
		PTRP_RD_REST = 2'b00,
		PTRP_RD_MOVE = 2'b01,
		PTRP_RD_HOLD = 2'b10,
		PTRP_RD_HALT = 2'b11
	} ptrp_rd_state_e;
endpackage : ptrp_pkg

// ### design/ptrp_reader_seq.sv
`timescale 1ns/1ps
`include "ptrp_cfg.svh"

module ptrp_reader_seq
	import ptrp_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic ce,
	input wire logic clear,
	input wire logic running,
	input wire logic stopReq,
	input wire logic stepMode,
	input wire logic readerSel,
	input wire logic bufferFull,
	input wire logic charStrobe,
	output logic motorGo,
	output logic stopDone,
	output ptrp_rd_state_e state
);
	ptrp_rd_state_e next_state;
	logic go;

	////////////////////////////////////////////////////////////////
	always_comb begin
		next_state = state;
		case (state)
			PTRP_RD_REST: begin
				if (running && readerSel) begin
					next_state = (stepMode && bufferFull) ? PTRP_RD_HOLD : PTRP_RD_MOVE;
				end
			end
			PTRP_RD_MOVE: begin
				if (!readerSel) begin
					next_state = PTRP_RD_REST;
				end else if (stopReq) begin
					next_state = PTRP_RD_HALT;
				end else if (charStrobe && stepMode) begin
					next_state = PTRP_RD_HOLD;
				end
			end
			PTRP_RD_HOLD: begin
				if (!readerSel || stopReq) begin
					next_state = PTRP_RD_REST;
				end else if (!stepMode || !bufferFull) begin
					next_state = PTRP_RD_MOVE;
				end
			end
			default: begin
				// finish the character under way, then park on the next
				if (charStrobe || !readerSel) begin
					next_state = PTRP_RD_REST;
				end
			end
		endcase
		if (clear) begin
			next_state = PTRP_RD_REST;
		end
	end

	always_comb begin
		go = (next_state == PTRP_RD_MOVE) || (next_state == PTRP_RD_HALT);
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state <= PTRP_RD_REST;
			motorGo <= 1'b0;
			stopDone <= 1'b0;
		end else if (ce) begin
			state <= next_state;
			motorGo <= go && readerSel;
			stopDone <= (state == PTRP_RD_HALT) && (next_state == PTRP_RD_REST);
		end
	end
endmodule : ptrp_reader_seq

// ### design/ptrp_ctrl.sv
`timescale 1ns/1ps
`include "ptrp_cfg.svh"

module ptrp_ctrl
	import ptrp_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`PTRP_ADDR_W-1:0] paddr,
	input wire logic [`PTRP_DATA_W-1:0] pwdata,
	output logic [`PTRP_DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic processor_clear_switch,
	input wire logic [`PTRP_CHAR_W-1:0] readerChar,
	input wire logic readerStrobe,
	input wire logic readerPowerOk,
	input wire logic readerLoadLever,
	output logic readerMotorGo,
	output logic [`PTRP_CHAR_W-1:0] punchData,
	output logic punchStrobe,
	input wire logic punchDone,
	input wire logic punchPowerButton,
	input wire logic punchOnline,
	input wire logic punchLowTape,
	output logic punchMotorOn,
	output logic deviceInterrupt
);
	logic clear;
	logic intEnable;
	logic running;
	logic stopReq;
	logic step_mode;
	logic punchSel;
	logic progPower;
	logic punchStopPending;
	logic cmdPunch;
	logic bufferFull;
	logic [`PTRP_CHAR_W-1:0] charBuf;
	logic overrun_flag;
	logic tapeStopLatch;
	logic tape_stopped_flag;
	logic buffer_wait_flag;
	logic attention_flag;
	logic device_unavailable_flag;
	logic access;
	logic wrDone;
	logic rdDone;
	logic cmdWr;
	logic dataWr;
	logic dataRd;
	logic mapped;
	logic readerLoad;
	logic motorNow;
	logic stopDone;
	logic [`PTRP_CHAR_W-1:0] cmd;
	logic [`PTRP_DATA_W-1:0] next_prdata;
	ptrp_rd_state_e rdState;

	function automatic logic isAddr(input logic [`PTRP_ADDR_W-1:0] a,
		input logic [`PTRP_ADDR_W-1:0] ref_a);
		isAddr = (a == ref_a);
	endfunction : isAddr
	////////////////////////////////////////////////////////////////
	// apb decode, one wait state so read data leaves a flop
	assign clear = processor_clear_switch;
	assign access = psel && penable && pready;
	assign wrDone = access && pwrite;
	assign rdDone = access && !pwrite;
	assign mapped = isAddr(paddr, `PTRP_ADDR_CMD) || isAddr(paddr, `PTRP_ADDR_STATUS)
		|| isAddr(paddr, `PTRP_ADDR_DATA) || isAddr(paddr, `PTRP_ADDR_MODE);
	assign cmdWr = wrDone && isAddr(paddr, `PTRP_ADDR_CMD);
	assign dataWr = wrDone && isAddr(paddr, `PTRP_ADDR_DATA);
	assign dataRd = rdDone && isAddr(paddr, `PTRP_ADDR_DATA);
	assign cmd = pwdata[`PTRP_CHAR_W-1:0];

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else if (ce) begin
			pready <= psel && penable && !pready;
			pslverr <= psel && penable && !pready && !mapped;
			prdata <= next_prdata;
		end
	end

	always_comb begin
		next_prdata = 32'h0000_0000;
		if (isAddr(paddr, `PTRP_ADDR_STATUS)) begin
			next_prdata[`PTRP_ST_OVERRUN] = overrun_flag;
			next_prdata[`PTRP_ST_STOPPED] = tape_stopped_flag;
			next_prdata[`PTRP_ST_WAIT] = buffer_wait_flag;
			next_prdata[`PTRP_ST_ATTN] = attention_flag;
			next_prdata[`PTRP_ST_UNAVAIL] = device_unavailable_flag;
		end else if (isAddr(paddr, `PTRP_ADDR_DATA)) begin
			next_prdata[`PTRP_CHAR_W-1:0] = punchSel ? 8'h00 : charBuf;
		end else if (isAddr(paddr, `PTRP_ADDR_MODE)) begin
			next_prdata[`PTRP_MODE_INTEN] = intEnable;
			next_prdata[`PTRP_MODE_RUNNING] = running;
			next_prdata[`PTRP_MODE_STEP] = step_mode;
			next_prdata[`PTRP_MODE_PUNCH] = punchSel;
			next_prdata[`PTRP_MODE_PWR] = punchMotorOn;
			next_prdata[`PTRP_MODE_FULL] = bufferFull;
		end
	end

	////////////////////////////////////////////////////////////////
	// command state; disable beats enable when both bits are set
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			intEnable <= 1'b0;
		end else if (ce) begin
			if (clear) begin
				intEnable <= 1'b0;
			end else if (cmdWr && cmd[`PTRP_CMD_DISABLE]) begin
				intEnable <= 1'b0;
			end else if (cmdWr && cmd[`PTRP_CMD_ENABLE]) begin
				intEnable <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			running <= 1'b0;
			step_mode <= 1'b1;
			punchSel <= 1'b0;
		end else if (ce) begin
			if (clear) begin
				running <= 1'b0;
				step_mode <= 1'b1;
				punchSel <= 1'b0;
			end else if (cmdWr) begin
				// stop wins over run; selecting the punch stops the reader
				if (cmd[`PTRP_CMD_STOP] || cmd[`PTRP_CMD_WRITE]) begin
					running <= 1'b0;
				end else if (cmd[`PTRP_CMD_RUN]) begin
					running <= 1'b1;
				end
				if (cmd[`PTRP_CMD_STEP]) begin
					step_mode <= 1'b1;
				end else if (cmd[`PTRP_CMD_CONT]) begin
					step_mode <= 1'b0;
				end
				if (cmd[`PTRP_CMD_WRITE]) begin
					punchSel <= 1'b1;
				end else if (cmd[`PTRP_CMD_READ]) begin
					punchSel <= 1'b0;
				end
			end
		end
	end

	// stop request is a one-cycle pulse into the sequencer
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			stopReq <= 1'b0;
		end else if (ce) begin
			stopReq <= cmdWr && (cmd[`PTRP_CMD_STOP] || cmd[`PTRP_CMD_WRITE]) && !clear;
		end
	end

	////////////////////////////////////////////////////////////////
	// reader tape motion
	ptrp_reader_seq uSeq (
		.clk(clk),
		.nrst(nrst),
		.ce(ce),
		.clear(clear),
		.running(running),
		.stopReq(stopReq),
		.stepMode(step_mode),
		.readerSel(!punchSel),
		.bufferFull(bufferFull),
		.charStrobe(readerStrobe),
		.motorGo(readerMotorGo),
		.stopDone(stopDone),
		.state(rdState)
	);

	// a strobe counts only while this end moves the reader tape
	assign motorNow = (rdState == PTRP_RD_MOVE) || (rdState == PTRP_RD_HALT);
	assign readerLoad = readerStrobe && motorNow && !punchSel;

	////////////////////////////////////////////////////////////////
	// shared character buffer
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			bufferFull <= 1'b0;
			charBuf <= 8'h00;
		end else if (ce) begin
			if (clear) begin
				bufferFull <= 1'b0;
			end else if (punchSel) begin
				if (dataWr && !bufferFull) begin
					charBuf <= cmd;
					bufferFull <= 1'b1;
				end else if (punchDone && bufferFull) begin
					bufferFull <= 1'b0;
				end
			end else if (readerLoad) begin
				charBuf <= readerChar; // load wins over a same-cycle take
				bufferFull <= 1'b1;
			end else if (dataRd) begin
				bufferFull <= 1'b0;
			end
			if (cmdWr && (cmd[`PTRP_CMD_WRITE] != cmd[`PTRP_CMD_READ])
				&& (cmd[`PTRP_CMD_WRITE] != punchSel)) begin
				bufferFull <= 1'b0; // mode change by a lone read or write bit starts with an empty buffer
			end
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			overrun_flag <= 1'b0;
		end else if (ce) begin
			if (clear || punchSel) begin
				overrun_flag <= 1'b0;
			end else if (readerLoad && bufferFull && !dataRd) begin
				overrun_flag <= 1'b1;
			end else if (dataRd) begin
				overrun_flag <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			tapeStopLatch <= 1'b1;
		end else if (ce) begin
			if (clear) begin
				tapeStopLatch <= 1'b1;
			end else if (stopDone) begin
				tapeStopLatch <= 1'b1;
			end else if (motorNow) begin
				tapeStopLatch <= 1'b0;
			end
		end
	end

	// status flags, reset to the processor clear picture with device unavailable also set
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			tape_stopped_flag <= 1'b1;
			buffer_wait_flag <= 1'b1;
			attention_flag <= 1'b1;
			device_unavailable_flag <= 1'b1;
		end else if (ce) begin
			if (clear) begin
				tape_stopped_flag <= 1'b1;
				buffer_wait_flag <= 1'b1;
				attention_flag <= 1'b1;
			end else begin
				tape_stopped_flag <= tapeStopLatch && !punchSel;
				buffer_wait_flag <= punchSel ? bufferFull : !bufferFull;
				attention_flag <= !punchSel && (overrun_flag || tapeStopLatch);
			end
			device_unavailable_flag <= punchSel
				? (!punchMotorOn || !punchOnline || punchLowTape)
				: (!readerPowerOk || readerLoadLever);
		end
	end

	////////////////////////////////////////////////////////////////
	// punch: program power follows run and stop, button overrides
	assign cmdPunch = cmd[`PTRP_CMD_WRITE] || (punchSel && !cmd[`PTRP_CMD_READ]);
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			progPower <= 1'b0;
			punchStopPending <= 1'b0;
		end else if (ce) begin
			if (clear) begin
				progPower <= 1'b0;
				punchStopPending <= 1'b0;
			end else if (cmdWr && cmdPunch && cmd[`PTRP_CMD_STOP]) begin
				punchStopPending <= 1'b1;
			end else if (cmdWr && cmdPunch && cmd[`PTRP_CMD_RUN]) begin
				progPower <= punchOnline;
				punchStopPending <= 1'b0;
			end else if (punchStopPending && !bufferFull) begin
				progPower <= 1'b0;
				punchStopPending <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			punchMotorOn <= 1'b0;
			punchStrobe <= 1'b0;
			punchData <= 8'h00;
		end else if (ce) begin
			// released online switch gates program power off at the motor without clearing it
			punchMotorOn <= punchPowerButton || (progPower && punchOnline);
			punchStrobe <= punchSel && dataWr && !bufferFull && !clear;
			if (punchSel && dataWr && !bufferFull) begin
				punchData <= cmd;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			deviceInterrupt <= 1'b0;
		end else if (ce) begin
			deviceInterrupt <= intEnable && !clear
				&& (punchSel ? !bufferFull : bufferFull);
		end
	end
endmodule : ptrp_ctrl

// ### verification/ptrp_ctrl_props.sv
`timescale 1ns/1ps

module ptrp_ctrl_props (
	input wire logic clk,
	input wire logic nrst,
	input wire logic processor_clear_switch,
	input wire logic readerStrobe,
	input wire logic readerMotorGo,
	input wire logic punchStrobe,
	input wire logic punchPowerButton,
	input wire logic punchOnline,
	input wire logic punchMotorOn,
	input wire logic deviceInterrupt
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);

	// prog power is dropped at the first edge, the output follows at the next
	sequence clrHeld;
		processor_clear_switch ##1 processor_clear_switch && !punchPowerButton;
	endsequence

	clr_no_intr_a: assert property (processor_clear_switch |=> !deviceInterrupt)
		else $error("interrupt during clear");
	clr_no_punch_a: assert property (processor_clear_switch |=> !punchStrobe)
		else $error("punch strobe during clear");
	clr_pwr_off_a: assert property (clrHeld |=> !punchMotorOn)
		else $error("punch power kept on by clear");
	btn_pwr_on_a: assert property (punchPowerButton |=> punchMotorOn)
		else $error("punch power off with button latched");
	local_pwr_off_a: assert property (!punchPowerButton && !punchOnline |=> !punchMotorOn)
		else $error("punch power on while offline");
	mech_excl_a: assert property (!(readerMotorGo && punchStrobe))
		else $error("reader and punch move together");
	reader_halt_a: assert property ($fell(readerMotorGo) |-> $past(readerStrobe) ||
		$past(readerStrobe, 2) || $past(processor_clear_switch) ||
		$past(processor_clear_switch, 2))
		else $error("reader stopped between characters");
	punch_busy_a: assert property (punchStrobe |=> !deviceInterrupt && !punchStrobe)
		else $error("punch ready while buffer full");
endmodule : ptrp_ctrl_props

bind ptrp_ctrl ptrp_ctrl_props ptrp_ctrl_props_i (.clk(clk), .nrst(nrst),
	.processor_clear_switch(processor_clear_switch), .readerStrobe(readerStrobe),
	.readerMotorGo(readerMotorGo), .punchStrobe(punchStrobe),
	.punchPowerButton(punchPowerButton), .punchOnline(punchOnline),
	.punchMotorOn(punchMotorOn), .deviceInterrupt(deviceInterrupt));

// ### verification/ptrp_tape_model.sv
`timescale 1ns/1ps

module ptrp_tape_model (
	input wire logic clk,
	input wire logic nrst,
	input wire logic slow,
	input wire logic readerMotorGo,
	input wire logic punchStrobe,
	output logic [7:0] readerChar,
	output logic readerStrobe,
	output logic punchDone
);
	logic [7:0] tapeChar;
	logic [4:0] rdCnt;
	logic [4:0] pnCnt;
	logic pnBusy;
	logic [4:0] gap;

	assign gap = slow ? 5'h0C : 5'h04;
	// sense lines hold nothing valid between strobes, so show the inverse
	assign readerChar = readerStrobe ? tapeChar : ~tapeChar;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rdCnt <= '0;
			tapeChar <= 8'hA0;
			readerStrobe <= 1'b0;
		end else begin
			readerStrobe <= 1'b0;
			if (readerStrobe) begin
				tapeChar <= tapeChar + 8'h01;
			end
			if (!readerMotorGo) begin
				rdCnt <= '0;
			end else if (rdCnt == gap) begin
				rdCnt <= '0;
				readerStrobe <= 1'b1;
			end else begin
				rdCnt <= rdCnt + 5'h01;
			end
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pnBusy <= 1'b0;
			pnCnt <= '0;
			punchDone <= 1'b0;
		end else begin
			punchDone <= 1'b0;
			if (punchStrobe) begin
				pnBusy <= 1'b1;
				pnCnt <= '0;
			end else if (pnBusy && pnCnt == gap) begin
				pnBusy <= 1'b0;
				punchDone <= 1'b1;
			end else if (pnBusy) begin
				pnCnt <= pnCnt + 5'h01;
			end
		end
	end
endmodule : ptrp_tape_model

// ### verification/paper_tape_reader_punch_ctrl_tb.sv
`timescale 1ns/1ps
`include "ptrp_cfg.svh"

module paper_tape_reader_punch_ctrl_tb;
	localparam logic [31:0] ONE = 32'h0000_0001;
	logic clk, nrst, psel, penable, pwrite, pready, pslverr, clr, slow;
	logic rdStb, rdGo, pnStb, pnDone, pnBtn, online, pnMotor, intr, rerr;
	logic [7:0] paddr, rdChar, pnData, lastChar;
	logic [31:0] pwdata, prdata, rdata;
	int num_errors = 0;
	int check_count = 0;
	int strobes = 0;

	ptrp_ctrl ptrp_ctrl_i (.clk(clk), .nrst(nrst), .ce(1'b1), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.processor_clear_switch(clr), .readerChar(rdChar), .readerStrobe(rdStb),
		.readerPowerOk(1'b1), .readerLoadLever(1'b0), .readerMotorGo(rdGo),
		.punchData(pnData), .punchStrobe(pnStb), .punchDone(pnDone),
		.punchPowerButton(pnBtn), .punchOnline(online), .punchLowTape(1'b0),
		.punchMotorOn(pnMotor), .deviceInterrupt(intr));
	ptrp_tape_model ptrp_tape_model_i (.clk(clk), .nrst(nrst), .slow(slow),
		.readerMotorGo(rdGo), .punchStrobe(pnStb), .readerChar(rdChar),
		.readerStrobe(rdStb), .punchDone(pnDone));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	always @(posedge clk) begin
		if (rdStb) lastChar <= rdChar;
		if (pnStb) strobes <= strobes + 1;
	end

	////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e) begin
			num_errors++;
			$display("MISMATCH %0t got %h exp %h", $time, g, e);
		end
	endtask : chk

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		chk(32'(pready), ONE);
		rdata = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : apb

	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		apb(1'b0, a, '0);
		chk(rdata & m, e);
	endtask : rd

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr

	function automatic logic [31:0] cmd(input int b);
		return ONE << b;
	endfunction : cmd

	function automatic logic sig(input int k);
		case (k)
			0: return intr;
			1: return rdGo;
			2: return pnStb;
			3: return pnDone;
			default: return rdStb;
		endcase
	endfunction : sig

	task automatic waitsig(input int k, input logic v);
		int n;
		n = 0;
		while (sig(k) !== v && n < 500) begin
			@(posedge clk);
			n++;
		end
		chk(32'(sig(k)), 32'(v));
	endtask : waitsig

	task complete_run;
		$display("errors %0d checks %0d", num_errors, check_count);
		if (num_errors == 0 && check_count > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : complete_run

	////////////////////////////////////////////////////////////////
	initial begin
		#300000;
		num_errors++;
		$display("MISMATCH %0t watchdog", $time);
		complete_run;
	end

	initial begin
		nrst = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		clr = 1'b0;
		pnBtn = 1'b0;
		online = 1'b1;
		slow = 1'b0;
		repeat (16) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		rd(`PTRP_ADDR_STATUS, 32'h0000_009C, 32'h0000_001C);
		rd(`PTRP_ADDR_MODE, 32'h0000_000F, 32'h0000_0004);
		rd(8'h10, '1, '0);
		chk(32'(rerr), ONE);
		// step mode: one character, then wait for the data read
		wr(`PTRP_ADDR_CMD, cmd(`PTRP_CMD_ENABLE) | cmd(`PTRP_CMD_RUN));
		waitsig(0, 1'b1);
		repeat (3) @(posedge clk);
		chk(32'(rdGo), '0);
		rd(`PTRP_ADDR_STATUS, 32'h0000_0088, '0);
		rd(`PTRP_ADDR_DATA, 32'h0000_00FF, 32'(lastChar));
		waitsig(1, 1'b1);
		waitsig(0, 1'b1);
		wr(`PTRP_ADDR_CMD, cmd(`PTRP_CMD_DISABLE));
		repeat (2) @(posedge clk);
		chk(32'(intr), '0);
		wr(`PTRP_ADDR_CMD, cmd(`PTRP_CMD_ENABLE));
		repeat (2) @(posedge clk);
		chk(32'(intr), ONE);
		// continuous over a full buffer, then stop
		wr(`PTRP_ADDR_CMD, cmd(`PTRP_CMD_CONT) | cmd(`PTRP_CMD_RUN));
		waitsig(4, 1'b1);
		@(posedge clk);
		waitsig(4, 1'b1);
		wr(`PTRP_ADDR_CMD, cmd(`PTRP_CMD_STOP));
		waitsig(1, 1'b0);
		repeat (3) @(posedge clk);
		rd(`PTRP_ADDR_STATUS, 32'h0000_009C, 32'h0000_0094);
		rd(`PTRP_ADDR_DATA, 32'h0000_00FF, 32'(lastChar));
		rd(`PTRP_ADDR_STATUS, 32'h0000_008C, 32'h0000_000C);
		// punch side, slow mechanism
		slow <= 1'b1;
		wr(`PTRP_ADDR_CMD, cmd(`PTRP_CMD_WRITE) | cmd(`PTRP_CMD_RUN));
		repeat (3) @(posedge clk);
		chk(32'(pnMotor), ONE);
		chk(32'(rdGo), '0);
		chk(32'(intr), ONE);
		rd(`PTRP_ADDR_STATUS, 32'h0000_0094, '0);
		wr(`PTRP_ADDR_DATA, 32'h0000_005A);
		waitsig(2, 1'b1);
		chk(32'(pnData), 32'h0000_005A);
		rd(`PTRP_ADDR_STATUS, 32'h0000_0008, 32'h0000_0008);
		wr(`PTRP_ADDR_DATA, 32'h0000_00A5);
		waitsig(3, 1'b1);
		repeat (3) @(posedge clk);
		chk(32'(intr), ONE);
		chk(32'(strobes), ONE);
		wr(`PTRP_ADDR_CMD, cmd(`PTRP_CMD_STOP));
		repeat (4) @(posedge clk);
		chk(32'(pnMotor), '0);
		online <= 1'b0;
		wr(`PTRP_ADDR_CMD, cmd(`PTRP_CMD_RUN));
		repeat (3) @(posedge clk);
		chk(32'(pnMotor), '0);
		pnBtn <= 1'b1;
		repeat (2) @(posedge clk);
		chk(32'(pnMotor), ONE);
		pnBtn <= 1'b0;
		online <= 1'b1;
		wr(`PTRP_ADDR_CMD, cmd(`PTRP_CMD_RUN));
		repeat (3) @(posedge clk);
		chk(32'(pnMotor), ONE);
		// processor clear in mid-run
		clr <= 1'b1;
		repeat (2) @(posedge clk);
		clr <= 1'b0;
		repeat (2) @(posedge clk);
		chk(32'(pnMotor), '0);
		chk(32'(intr), '0);
		rd(`PTRP_ADDR_MODE, 32'h0000_000F, 32'h0000_0004);
		rd(`PTRP_ADDR_STATUS, 32'h0000_009C, 32'h0000_001C);
		// read and continuous decode, then step beating continuous
		wr(`PTRP_ADDR_CMD, cmd(`PTRP_CMD_WRITE));
		wr(`PTRP_ADDR_CMD, cmd(`PTRP_CMD_READ) | cmd(`PTRP_CMD_CONT));
		rd(`PTRP_ADDR_MODE, 32'h0000_000C, 32'h0000_0000);
		wr(`PTRP_ADDR_CMD, cmd(`PTRP_CMD_STEP) | cmd(`PTRP_CMD_CONT));
		rd(`PTRP_ADDR_MODE, 32'h0000_000C, 32'h0000_0004);
		complete_run;
	end
endmodule : paper_tape_reader_punch_ctrl_tb
